// File: design/angle_memory_map.svh
// constants for the voltage angle memory: offsets, fields, resets, timing
// assumes a 10 MHz clock and 32-bit avalon data with byte addresses
`ifndef ANGLE_MEM_MAP_SVH
`define ANGLE_MEM_MAP_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ACT_VOLT 8'h04
`define OFS_CUR_PICKUP 8'h08
`define OFS_MAX_TIME 8'h0C
`define OFS_EVT_FILTER 8'h10
`define OFS_EVT_STATUS 8'h14
`define OFS_EVT_MASK 8'h18
`define OFS_LIVE 8'h1C
`define OFS_ANGLE 8'h20

// control fields
`define CTRL_EN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_CUR_COND_BIT 3
`define CTRL_FORCED_CT_BIT 4
`define CTRL_SIXTY_HZ_BIT 5

// reset values; voltage in 10 mV, time in 10 ms steps
`define RST_ACT_VOLT 16'h03E8
`define RST_CUR_PICKUP 16'h0064
`define RST_MAX_TIME 16'h0032
`define RST_EVT_FILTER 12'hFFF
`define ACT_VOLT_MIN 16'h00C8
`define ACT_VOLT_MAX 16'h1388
`define MAX_TIME_MIN 16'h0002
`define MAX_TIME_MAX 16'h1388

// timing: one step of the active-time counter
`define CLK_FREQ_MHZ 10
`define TIME_STEP_US 10000
`define TIME_STEP_CYC (`TIME_STEP_US * `CLK_FREQ_MHZ)

`endif

// File: design/angle_memory_pkg.sv
// types shared by the voltage angle memory block
// assumes the map header supplies the numeric constants
package angle_mem_pkg;

    typedef enum logic [1:0] {
        three_phase_neutral_mode,
        three_line_line_mode,
        two_line_line_mode,
        two_line_plus_residual_mode
    } volt_mode_type;

    typedef enum logic [1:0] {
        mem_idle,
        mem_active,
        mem_expired
    } mem_state_type;

    // one refresh of rms values, 10 mV / 10 mA units
    typedef struct packed {
        logic [15:0] phase_a_current_rms;
        logic [15:0] phase_b_current_rms;
        logic [15:0] phase_c_current_rms;
        logic [15:0] volt_chan1_rms;
        logic [15:0] volt_chan2_rms;
        logic [15:0] volt_chan3_rms;
        logic [15:0] volt_chan4_rms;
        logic [2:0][15:0] calc_pn_rms;
        logic [15:0] angle;
    } meas_type;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avl_req_type;

    // reference handed to the directional stages
    typedef struct packed {
        logic [15:0] amplitude;
        logic [15:0] angle;
    } vref_type;

endpackage

// File: design/voltage_angle_memory.sv
// voltage angle memory: decides when measured voltages are replaced by a memorised reference
// assumes rms inputs refreshed by a one-cycle meas_valid_i strobe every 5 ms, avalon-mm master
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`include "angle_memory_map.svh"

// Notes on behaviour
// - take phase currents and voltages every 5 ms
// - pick channels per three- or two-line mode
// - residual mode uses computed phase-neutral voltages
// - activate when all used voltages below threshold
// - optional current condition needs one high current
// - limit memory use by definite maximum time
// - after time expires stop supplying memorised voltage
// - fixed tracking uses set 50 or 60 Hz
// - forced tracking takes frequency from phase c current
// - filtered rising/falling status events
// - reference amplitude is threshold, angle pre-fault
// - memory-on output while memory active
// - sample blocking input each processing cycle
module voltage_angle_memory #(
    parameter int unsigned STEP_CYC = `TIME_STEP_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register bus
    input wire angle_mem_pkg::avl_req_type avl_req_i,
    output logic [31:0] avl_readdata_o,
    output logic avl_waitrequest_o,
    // measurements and blocking
    input wire angle_mem_pkg::meas_type meas_i,
    input wire logic meas_valid_i,
    input wire logic block_i,
    // results
    output angle_mem_pkg::vref_type vref_o,
    output logic mem_on_o,
    output logic freq_from_ct_o,
    output logic freq_sixty_hz_o,
    output logic irq_o
);
    import angle_mem_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic wait_req;
        logic enable;
        volt_mode_type mode;
        logic cur_cond;
        logic forced_ct;
        logic sixty_hz;
        logic [15:0] act_volt;
        logic [15:0] cur_pickup;
        logic [15:0] max_time;
        logic [11:0] evt_filter;
        logic [11:0] evt_status;
        logic [11:0] evt_mask;
        logic blocked;
        logic volt_low;
        logic cur_high;
        mem_state_type mstate;
        logic [15:0] steps;
        logic [31:0] prescale;
        logic [15:0] pre_angle;
        logic [5:0] prev_lvl;
        vref_type vref;
        logic mem_on;
        logic from_ct;
        logic irq;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    // clamp a setting into its allowed range
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // true when a value sits below the threshold
    function automatic logic below(input logic [15:0] v, input logic [15:0] thr);
        below = (v < thr);
    endfunction

    logic [5:0] lvl;
    logic [11:0] evt_set;
    logic [2:0] low_vec;
    logic [2:0] high_vec;
    logic step_done;

    // per-phase current pick-up compare
    assign high_vec[0] = meas_i.phase_a_current_rms > state_ff.cur_pickup;
    assign high_vec[1] = meas_i.phase_b_current_rms > state_ff.cur_pickup;
    assign high_vec[2] = meas_i.phase_c_current_rms > state_ff.cur_pickup;

    // channel choice by voltage mode
    always_comb begin
        case (state_ff.mode)
            three_phase_neutral_mode, three_line_line_mode: begin
                low_vec[0] = below(meas_i.volt_chan1_rms, state_ff.act_volt);
                low_vec[1] = below(meas_i.volt_chan2_rms, state_ff.act_volt);
                low_vec[2] = below(meas_i.volt_chan3_rms, state_ff.act_volt);
            end
            two_line_line_mode: begin
                // only the 1-2 and 3-2 line voltages exist here
                low_vec[0] = below(meas_i.volt_chan1_rms, state_ff.act_volt);
                low_vec[1] = below(meas_i.volt_chan2_rms, state_ff.act_volt);
                low_vec[2] = 1'b1;
            end
            two_line_plus_residual_mode: begin
                low_vec[0] = below(meas_i.calc_pn_rms[0], state_ff.act_volt);
                low_vec[1] = below(meas_i.calc_pn_rms[1], state_ff.act_volt);
                low_vec[2] = below(meas_i.calc_pn_rms[2], state_ff.act_volt);
            end
            default: begin
                low_vec = 3'h0;
            end
        endcase
    end

    // status levels watched for events
    assign lvl = {state_ff.blocked, state_ff.mem_on, state_ff.from_ct,
                  state_ff.cur_high, state_ff.volt_low, state_ff.enable};

    // rising edges into low half, falling edges into high half, each filtered
    assign evt_set = {(~lvl & state_ff.prev_lvl), (lvl & ~state_ff.prev_lvl)} & state_ff.evt_filter;

    assign step_done = (state_ff.prescale == 32'(STEP_CYC - 1));

    always_comb begin
        logic [31:0] wd;
        logic do_wr;
        logic act_cond;
        wd = avl_req_i.writedata;
        do_wr = 1'b0;
        act_cond = 1'b0;
        nxt_state = state_ff;
        nxt_state.prev_lvl = lvl;

        // bus: first cycle of a request prepares read data, second releases the master
        if ((avl_req_i.read || avl_req_i.write) && state_ff.wait_req) begin
            nxt_state.wait_req = 1'b0;
            case (avl_req_i.address)
                `OFS_CTRL: nxt_state.rdata = {26'h0, state_ff.sixty_hz, state_ff.forced_ct,
                                               state_ff.cur_cond, state_ff.mode, state_ff.enable};
                `OFS_ACT_VOLT: nxt_state.rdata = {16'h0, state_ff.act_volt};
                `OFS_CUR_PICKUP: nxt_state.rdata = {16'h0, state_ff.cur_pickup};
                `OFS_MAX_TIME: nxt_state.rdata = {16'h0, state_ff.max_time};
                `OFS_EVT_FILTER: nxt_state.rdata = {20'h0, state_ff.evt_filter};
                `OFS_EVT_STATUS: nxt_state.rdata = {20'h0, state_ff.evt_status};
                `OFS_EVT_MASK: nxt_state.rdata = {20'h0, state_ff.evt_mask};
                `OFS_LIVE: nxt_state.rdata = {24'h0, state_ff.mstate, lvl};
                `OFS_ANGLE: nxt_state.rdata = {state_ff.vref.angle, state_ff.pre_angle};
                default: nxt_state.rdata = 32'h0; // unmapped reads zero
            endcase
        end else if (!state_ff.wait_req) begin
            nxt_state.wait_req = 1'b1;
            do_wr = avl_req_i.write;
        end

        // register writes land on the edge where waitrequest is seen low
        if (do_wr) begin
            case (avl_req_i.address)
                `OFS_CTRL: begin
                    nxt_state.enable = wd[`CTRL_EN_BIT];
                    nxt_state.mode = volt_mode_type'(wd[`CTRL_MODE_LSB +: 2]);
                    nxt_state.cur_cond = wd[`CTRL_CUR_COND_BIT];
                    nxt_state.forced_ct = wd[`CTRL_FORCED_CT_BIT];
                    nxt_state.sixty_hz = wd[`CTRL_SIXTY_HZ_BIT];
                end
                `OFS_ACT_VOLT: nxt_state.act_volt = clamp(wd[15:0], `ACT_VOLT_MIN, `ACT_VOLT_MAX);
                `OFS_CUR_PICKUP: nxt_state.cur_pickup = wd[15:0];
                `OFS_MAX_TIME: nxt_state.max_time = clamp(wd[15:0], `MAX_TIME_MIN, `MAX_TIME_MAX);
                `OFS_EVT_FILTER: nxt_state.evt_filter = wd[11:0];
                `OFS_EVT_MASK: nxt_state.evt_mask = wd[11:0];
                default: ;
            endcase
        end

        // sticky events; a new event beats a simultaneous write-one clear
        if (do_wr && (avl_req_i.address == `OFS_EVT_STATUS)) begin
            nxt_state.evt_status = state_ff.evt_status & ~wd[11:0];
        end
        nxt_state.evt_status = nxt_state.evt_status | evt_set;

        // processing cycle: decisions only on each fresh measurement set
        if (meas_valid_i) begin
            nxt_state.blocked = block_i;
            nxt_state.volt_low = &low_vec;
            nxt_state.cur_high = |high_vec;
            act_cond = state_ff.enable && (&low_vec) && (!state_ff.cur_cond || (|high_vec));
            case (state_ff.mstate)
                mem_idle: begin
                    if (act_cond && !block_i) begin
                        nxt_state.mstate = mem_active;
                        nxt_state.vref.angle = state_ff.pre_angle;
                        nxt_state.steps = 16'h0;
                        nxt_state.prescale = 32'h0;
                    end else begin
                        // healthy angle tracked until the fault, then frozen
                        nxt_state.pre_angle = meas_i.angle;
                    end
                end
                mem_active: begin
                    if (!act_cond || block_i) begin
                        nxt_state.mstate = mem_idle;
                    end
                end
                mem_expired: begin
                    // memory stays unused until the activation condition clears
                    if (!act_cond) begin
                        nxt_state.mstate = mem_idle;
                    end
                end
                default: nxt_state.mstate = mem_idle;
            endcase
        end

        // definite-time limit counted in 10 ms steps
        if (state_ff.mstate == mem_active) begin
            nxt_state.prescale = step_done ? 32'h0 : state_ff.prescale + 32'h1;
            if (step_done) begin
                nxt_state.steps = state_ff.steps + 16'h1;
                if (state_ff.steps + 16'h1 >= state_ff.max_time) begin
                    nxt_state.mstate = mem_expired;
                end
            end
        end
        if (block_i && meas_valid_i) begin
            nxt_state.mstate = (state_ff.mstate == mem_active) ? mem_idle : nxt_state.mstate;
        end

        // outputs follow the state one edge later
        nxt_state.mem_on = (state_ff.mstate == mem_active) && !state_ff.blocked;
        nxt_state.vref.amplitude = nxt_state.mem_on ? state_ff.act_volt : 16'h0;
        // current-based tracking only while voltages are gone
        nxt_state.from_ct = state_ff.forced_ct && state_ff.enable && state_ff.volt_low;
        nxt_state.irq = |(state_ff.evt_status & state_ff.evt_mask);
    end

    // one register bank for all state
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= '0;
            state_ff.wait_req <= 1'b1;
            state_ff.act_volt <= `RST_ACT_VOLT;
            state_ff.cur_pickup <= `RST_CUR_PICKUP;
            state_ff.max_time <= `RST_MAX_TIME;
            state_ff.evt_filter <= `RST_EVT_FILTER;
            state_ff.mstate <= mem_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // every output straight from the register bank
    assign avl_readdata_o = state_ff.rdata;
    assign avl_waitrequest_o = state_ff.wait_req;
    assign vref_o = state_ff.vref;
    assign mem_on_o = state_ff.mem_on;
    assign freq_from_ct_o = state_ff.from_ct;
    assign freq_sixty_hz_o = state_ff.sixty_hz;
    assign irq_o = state_ff.irq;

endmodule // voltage_angle_memory

// File: bench/meas_front_end.sv
// measurement front end model: hands a fresh rms set to the block on a refresh strobe
// assumes the bench sets the levels; PERIOD stands in for the 5 ms time base
module meas_front_end #(
    parameter int PERIOD = 20
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // levels chosen by the bench
    input wire angle_mem_pkg::meas_type level_i,
    // refresh toward the block
    output angle_mem_pkg::meas_type meas_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import angle_mem_pkg::*;
    int cnt_ff;

    // values change only together with the strobe, so a refresh is never torn
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 0;
            meas_o <= '0;
            valid_o <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
            valid_o <= (cnt_ff == PERIOD - 1);
            if (cnt_ff == PERIOD - 1) begin
                meas_o <= level_i;
            end
        end
    end
endmodule // meas_front_end

// File: bench/angle_memory_monitor.sv
// port-level checker for the voltage angle memory
// assumes one clock domain with async active-low reset; bound to every instance
`include "angle_memory_map.svh"
module angle_memory_checker #(
    parameter int unsigned STEP_CYC = 10
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register bus
    input wire angle_mem_pkg::avl_req_type avl_req_i,
    input wire logic [31:0] avl_readdata_o,
    input wire logic avl_waitrequest_o,
    // measurements
    input wire angle_mem_pkg::meas_type meas_i,
    input wire logic meas_valid_i,
    input wire logic block_i,
    // results
    input wire angle_mem_pkg::vref_type vref_o,
    input wire logic mem_on_o,
    input wire logic freq_from_ct_o,
    input wire logic freq_sixty_hz_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import angle_mem_pkg::*;
    localparam int unsigned ON_LIMIT = 5000 * STEP_CYC + 4;
    int unsigned on_cnt_ff;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // length of continuous memory use; a plain repetition would not unroll this far
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            on_cnt_ff <= 0;
        end else begin
            on_cnt_ff <= mem_on_o ? on_cnt_ff + 1 : 0;
        end
    end

    a_wait_one_cycle: assert property ((avl_req_i.read || avl_req_i.write) && avl_waitrequest_o |=> !avl_waitrequest_o)
        else $error("bus answer late");
    a_wait_single_low: assert property (!avl_waitrequest_o |=> avl_waitrequest_o)
        else $error("waitrequest low too long");
    a_amp_follows_on: assert property (mem_on_o ? (vref_o.amplitude >= `ACT_VOLT_MIN && vref_o.amplitude <= `ACT_VOLT_MAX) : vref_o.amplitude == 16'h0000)
        else $error("amplitude does not match memory state");
    a_block_keeps_off: assert property (meas_valid_i && block_i |-> ##2 !mem_on_o)
        else $error("memory on while blocked");
    a_rise_after_valid: assert property ($rose(mem_on_o) |-> $past(meas_valid_i, 2))
        else $error("memory rose outside a processing cycle");
    a_angle_held: assert property (mem_on_o && $past(mem_on_o) |-> $stable(vref_o.angle))
        else $error("memorised angle moved");
    a_on_time_limit: assert property (on_cnt_ff <= ON_LIMIT)
        else $error("memory use exceeded maximum time");
    a_sixty_by_write: assert property ($changed(freq_sixty_hz_o) |-> $past(avl_req_i.write) || $past(avl_req_i.write, 2))
        else $error("frequency select changed without a write");
endmodule // angle_memory_checker

bind voltage_angle_memory angle_memory_checker #(.STEP_CYC(STEP_CYC)) angle_memory_checker_inst (
    .clock_i, .rstn_i, .avl_req_i, .avl_readdata_o, .avl_waitrequest_o, .meas_i, .meas_valid_i,
    .block_i, .vref_o, .mem_on_o, .freq_from_ct_o, .freq_sixty_hz_o, .irq_o
);

// File: bench/tb_top.sv
// self-checking bench for the voltage angle memory
// assumes the front end model supplies refreshes; registers reached over the avalon bus
`include "angle_memory_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import angle_mem_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic block = 1'b0;
    logic wreq, mvalid, mem_on, from_ct, sixty, irq;
    logic [31:0] rdata;
    avl_req_type req = '0;
    meas_type lvl = '0;
    meas_type meas;
    vref_type vref;
    int bad_count = 0;
    int checked = 0;
    int tn = 0;

    // 10 MHz
    always #50 clock_i = ~clock_i;

    voltage_angle_memory #(.STEP_CYC(10)) voltage_angle_memory_inst (.clock_i(clock_i), .rstn_i(rstn_i),
        .avl_req_i(req), .avl_readdata_o(rdata), .avl_waitrequest_o(wreq), .meas_i(meas),
        .meas_valid_i(mvalid), .block_i(block), .vref_o(vref), .mem_on_o(mem_on),
        .freq_from_ct_o(from_ct), .freq_sixty_hz_o(sixty), .irq_o(irq));
    meas_front_end #(.PERIOD(20)) meas_front_end_inst (.clock_i(clock_i), .rstn_i(rstn_i),
        .level_i(lvl), .meas_o(meas), .valid_o(mvalid));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [7:0] a, input logic rd, input logic [31:0] d, output logic [31:0] q);
        req <= '{address: a, read: rd, write: !rd, writedata: d};
        do @(posedge clock_i); while (wreq !== 1'b0);
        q = rdata;
        req <= '0;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b0, d, q);
    endtask

    // chan4 stays healthy; it is never one of the used channels
    task automatic set_lv(input logic [15:0] c12, c3, pn, cur, ang);
        lvl <= {cur, cur, cur, c12, c12, c3, 16'h2710, pn, pn, pn, ang};
    endtask

    // skip a strobe that may carry levels from before the change
    task automatic wait_valid();
        @(posedge clock_i);
        @(posedge clock_i iff mvalid);
        repeat (3) @(posedge clock_i);
    endtask

    // healthy refresh, then a collapse with a new angle, then recovery
    task automatic episode(input logic [15:0] c3, pn, cur, input logic on);
        set_lv(16'h2710, 16'h2710, 16'h2710, cur, 16'h1234);
        wait_valid();
        set_lv(16'h0064, c3, pn, cur, 16'h5678);
        wait_valid();
        chk(mem_on, on);
        chk(vref.amplitude, on ? 16'h03E8 : 16'h0000);
        if (on) begin
            chk(vref.angle, 16'h1234);
        end
        set_lv(16'h2710, 16'h2710, 16'h2710, cur, 16'h1234);
        wait_valid();
        chk(mem_on, 1'b0);
    endtask

    task automatic done();
        tn++;
        $display("test %0d finished", tn);
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] q;
        logic [7:0] ofs [7] = '{`OFS_CTRL, `OFS_ACT_VOLT, `OFS_CUR_PICKUP, `OFS_MAX_TIME, `OFS_EVT_FILTER,
            `OFS_EVT_MASK, 8'h40};
        logic [31:0] rv [7] = '{32'h0, 32'h3E8, 32'h64, 32'h32, 32'hFFF, 32'h0, 32'h0};
        set_lv(16'h2710, 16'h2710, 16'h2710, 16'h0010, 16'h1234);
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        for (int i = 0; i < 7; i++) begin
            bus(ofs[i], 1'b1, 32'h0, q);
            chk(q, rv[i]);
        end
        chk(sixty, 1'b0);
        done();
        // enable raises its event; write-one clears it and drops the interrupt
        wr(`OFS_EVT_MASK, 32'hFFF);
        wr(`OFS_CTRL, 32'h1);
        repeat (4) @(posedge clock_i);
        bus(`OFS_EVT_STATUS, 1'b1, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        chk(irq, 1'b1);
        wr(`OFS_EVT_STATUS, 32'hFFF);
        repeat (4) @(posedge clock_i);
        bus(`OFS_EVT_STATUS, 1'b1, 32'h0, q);
        chk(q, 32'h0);
        chk(irq, 1'b0);
        done();
        // each voltage mode; in residual mode collapsed channel inputs alone stay off and collapsed computed ones switch on
        episode(16'h0064, 16'h2710, 16'h0010, 1'b1);
        episode(16'h2710, 16'h2710, 16'h0010, 1'b0);
        wr(`OFS_CTRL, 32'h3);
        episode(16'h0064, 16'h2710, 16'h0010, 1'b1);
        wr(`OFS_CTRL, 32'h5);
        episode(16'h2710, 16'h2710, 16'h0010, 1'b1);
        wr(`OFS_CTRL, 32'h7);
        episode(16'h0064, 16'h2710, 16'h0010, 1'b0);
        episode(16'h2710, 16'h0064, 16'h0010, 1'b1);
        done();
        // current condition, then blocking
        wr(`OFS_CTRL, 32'h9);
        episode(16'h0064, 16'h2710, 16'h0010, 1'b0);
        episode(16'h0064, 16'h2710, 16'h0200, 1'b1);
        block <= 1'b1;
        episode(16'h0064, 16'h2710, 16'h0200, 1'b0);
        block <= 1'b0;
        done();
        // shortest active time: 2 steps of 10 cycles, fault kept on
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_MAX_TIME, 32'h2);
        set_lv(16'h0064, 16'h0064, 16'h2710, 16'h0010, 16'h5678);
        wait_valid();
        chk(mem_on, 1'b1);
        repeat (30) @(posedge clock_i);
        chk(mem_on, 1'b0);
        chk(vref.amplitude, 16'h0000);
        done();
        // forced current tracking and 60 Hz select
        wr(`OFS_CTRL, 32'h31);
        wait_valid();
        chk(from_ct, 1'b1);
        chk(sixty, 1'b1);
        set_lv(16'h2710, 16'h2710, 16'h2710, 16'h0010, 16'h1234);
        wait_valid();
        chk(from_ct, 1'b0);
        done();
        // rising-only filter with everything masked
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_EVT_MASK, 32'h0);
        wr(`OFS_EVT_FILTER, 32'h03F);
        wr(`OFS_EVT_STATUS, 32'hFFF);
        episode(16'h0064, 16'h2710, 16'h0010, 1'b1);
        bus(`OFS_EVT_STATUS, 1'b1, 32'h0, q);
        chk(q & 32'h410, 32'h010);
        chk(irq, 1'b0);
        done();
        stop_test();
    end

    // whole run is about 750 cycles; some forty times that means a hang
    initial begin
        repeat (30000) @(posedge clock_i);
        bad_count++;
        stop_test();
    end
endmodule // tb_top
